// File: shared/udc_defines.vh
`ifndef UDC_DEFINES_VH
`define UDC_DEFINES_VH
`define UDC_CRC_SEED      16'h4aba
`define UDC_ERR_ICRC_BIT  7
`define UDC_ERR_ABRT_BIT  2
`define UDC_KEY_ABORTED   4'h0
`define UDC_KEY_ABORTED_V 4'hb
`define UDC_KEY_HW_ERR    4'h4
`define UDC_ASC_CRC       8'h08
`define UDC_ASCQ_CRC      8'h03
`define UDC_CMD_DMA       2'h0
`define UDC_CMD_REQSENSE  2'h1
`define UDC_CMD_PACKET    2'h2
`define UDC_CMD_NONE      2'h3
`define UDC_REG_CTRL      2'h0
`define UDC_REG_STATUS    2'h1
`define UDC_REG_REPORT    2'h2
`define UDC_REG_CRC       2'h3
`endif

// File: hdl/udc_crc_word.v
`include "udc_defines.vh"
module udc_crc_word (
    input  wire [15:0] cur,
    input  wire [15:0] data,
    output reg  [15:0] nxt
);
    reg [16:1] f;
    integer    k;
    integer    i;
    always @* begin
        f   = 16'h0000;
        nxt = 16'h0000;
        for (k = 1; k <= 16; k = k + 1) begin
            f[k] = data[k-1] ^ cur[16-k];
            if (k >= 5)
                f[k] = f[k] ^ f[k-4];
            if (k >= 12)
                f[k] = f[k] ^ f[k-11];
        end
        for (i = 0; i <= 15; i = i + 1) begin
            nxt[i] = f[16-i];
            if (i >= 5)
                nxt[i] = nxt[i] ^ f[21-i];
            if (i >= 12)
                nxt[i] = nxt[i] ^ f[28-i];
        end
    end
endmodule // udc_crc_word

// File: hdl/udc_crc_check.v
// The placing of the registers and the plain strobed port were left to the implementer.
`include "udc_defines.vh"
module udc_crc_check (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        clk_en,
    input  wire [1:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        cmd_start,
    input  wire        cmd_end,
    input  wire [1:0]  cmd_kind,
    input  wire        burst_start,
    input  wire        strobe,
    input  wire        term_ack,
    input  wire        dmack_n,
    input  wire [15:0] dd_in,
    input  wire        words_done,
    output reg         burst_stop,
    output reg  [15:0] word_data,
    output reg         word_valid,
    output reg  [7:0]  err_reg,
    output reg         chk_flag,
    output reg  [3:0]  sense_key,
    output reg  [7:0]  sense_asc,
    output reg  [7:0]  sense_ascq,
    output reg         report_valid
);
    // ****************************************************
    // control register: bit0 ultra mode, bit1 data-out
    // ****************************************************
    reg         udma_on;
    reg         dir_out;
    reg  [15:0] crc_current_state;
    wire [15:0] crc_next_state;
    reg         strobe_d;
    reg         dmack_d;
    reg         in_burst;
    reg         terminating;
    reg         err_seen;
    reg  [15:0] first_host_crc;
    reg  [15:0] first_dev_crc;
    reg         cmd_busy;
    reg  [1:0]  cur_kind;
    reg  [15:0] last_host_crc;
    wire        strobe_edge = strobe ^ strobe_d;
    wire        ack_fall    = dmack_d & ~dmack_n;
    wire        ack_rise    = ~dmack_d & dmack_n;
    wire        take_word   = in_burst & strobe_edge & ~terminating;

    udc_crc_word u_crc (
        .cur  (crc_current_state),
        .data (dd_in),
        .nxt  (crc_next_state)
    );

    // ****************************************************
    // crc engine, one per burst
    // ****************************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            crc_current_state <= `UDC_CRC_SEED;
            // strobe idles asserted; a low reset value would fake an edge
            strobe_d          <= 1'b1;
            dmack_d           <= 1'b1;
            in_burst          <= 1'b0;
            terminating       <= 1'b0;
            word_valid        <= 1'b0;
            word_data         <= 16'h0000;
            burst_stop        <= 1'b0;
        end else if (clk_en) begin
            strobe_d   <= strobe;
            dmack_d    <= dmack_n;
            word_valid <= 1'b0;
            if (burst_start | ack_fall) begin
                crc_current_state <= `UDC_CRC_SEED;
                in_burst          <= 1'b1;
                terminating       <= 1'b0;
                burst_stop        <= 1'b0;
            end else if (take_word) begin
                crc_current_state <= crc_next_state;
                // extra out-words after completion feed crc only
                if (!(dir_out & words_done)) begin
                    word_data  <= dd_in;
                    word_valid <= 1'b1;
                end
            end
            if (term_ack)
                terminating <= 1'b1;
            if (words_done & in_burst)
                burst_stop <= 1'b1;
            if (ack_rise) begin
                in_burst   <= 1'b0;
                burst_stop <= 1'b0;
            end
        end
    end

    // ****************************************************
    // compare and first-error capture
    // ****************************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            err_seen       <= 1'b0;
            first_host_crc <= 16'h0000;
            first_dev_crc  <= 16'h0000;
            last_host_crc  <= 16'h0000;
            cmd_busy       <= 1'b0;
            cur_kind       <= `UDC_CMD_NONE;
        end else if (clk_en) begin
            if (cmd_start) begin
                err_seen <= 1'b0;
                cmd_busy <= 1'b1;
                cur_kind <= cmd_kind;
            end else if (cmd_end)
                cmd_busy <= 1'b0;
            if (ack_rise & in_burst) begin
                last_host_crc <= dd_in;
                // a matching burst never clears err_seen; only the first is kept
                if (udma_on && dd_in != crc_current_state && !err_seen && !cmd_start) begin
                    err_seen       <= 1'b1;
                    first_host_crc <= dd_in;
                    first_dev_crc  <= crc_current_state;
                end
            end
        end
    end

    // ****************************************************
    // end-of-command reporting
    // ****************************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            err_reg      <= 8'h00;
            chk_flag     <= 1'b0;
            sense_key    <= `UDC_KEY_ABORTED;
            sense_asc    <= 8'h00;
            sense_ascq   <= 8'h00;
            report_valid <= 1'b0;
        end else if (clk_en) begin
            report_valid <= 1'b0;
            if (cmd_end & cmd_busy) begin
                report_valid <= 1'b1;
                err_reg      <= 8'h00;
                chk_flag     <= 1'b0;
                sense_key    <= `UDC_KEY_ABORTED;
                if (err_seen) begin
                    case (cur_kind)
                        `UDC_CMD_DMA: begin
                            err_reg[`UDC_ERR_ICRC_BIT] <= 1'b1;
                            err_reg[`UDC_ERR_ABRT_BIT] <= 1'b1;
                        end
                        `UDC_CMD_REQSENSE: begin
                            chk_flag  <= 1'b1;
                            sense_key <= `UDC_KEY_ABORTED_V;
                        end
                        `UDC_CMD_PACKET: begin
                            chk_flag   <= 1'b1;
                            sense_key  <= `UDC_KEY_HW_ERR;
                            sense_asc  <= `UDC_ASC_CRC;
                            sense_ascq <= `UDC_ASCQ_CRC;
                        end
                        default: begin
                            chk_flag <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************************
    // register port
    // ****************************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            udma_on   <= 1'b0;
            dir_out   <= 1'b0;
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `UDC_REG_CTRL) begin
                udma_on <= reg_wdata[0];
                dir_out <= reg_wdata[1];
            end
            if (reg_rd) begin
                case (reg_addr)
                    `UDC_REG_CTRL:   reg_rdata <= {14'h0000, dir_out, udma_on};
                    `UDC_REG_STATUS: reg_rdata <= {11'h000, cur_kind, cmd_busy, in_burst, err_seen};
                    `UDC_REG_REPORT: reg_rdata <= first_host_crc;
                    `UDC_REG_CRC:    reg_rdata <= crc_current_state;
                    default:         reg_rdata <= 16'h0000;
                endcase
            end else
                reg_rdata <= 16'h0000;
        end
    end
endmodule // udc_crc_check

// File: tb/udc_host_model.sv
module udc_host_model (
    input  wire         ref_clk,
    output logic        strobe,
    output logic        dmack_n,
    output logic        term_ack,
    output logic        burst_start,
    output logic [15:0] dd_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] crc;
    // ****************************************
    // host side burst with its own crc
    // ****************************************
    function automatic logic [15:0] nx(logic [15:0] c, logic [15:0] d);
        for (int i = 0; i < 16; i++) begin
            c = {c[14:0], 1'b0} ^ (((d[i] ^ c[15]) == 1'b1) ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction
    initial begin
        strobe = 1'b1;
        dmack_n = 1'b1;
        term_ack = 1'b0;
        burst_start = 1'b0;
        dd_in = 16'h0000;
    end
    // bad flips bits of the final crc word to force a miscompare
    task burst(input int n, input logic [15:0] base, input logic [15:0] bad);
        logic [15:0] w;
        crc = 16'h4aba;
        dmack_n <= 1'b0;
        burst_start <= 1'b1;
        dd_in <= ~dd_in;
        @(posedge ref_clk);
        burst_start <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            w = base + 16'(i);
            dd_in <= w;
            strobe <= ~strobe;
            crc = nx(crc, w);
            repeat (2) @(posedge ref_clk);
        end
        term_ack <= 1'b1;
        @(posedge ref_clk);
        if (!strobe) strobe <= 1'b1;
        dd_in <= ~dd_in;
        @(posedge ref_clk);
        dmack_n <= 1'b1;
        dd_in <= crc ^ bad;
        @(posedge ref_clk);
        term_ack <= 1'b0;
        dd_in <= ~(crc ^ bad);
        @(posedge ref_clk);
    endtask
endmodule // udc_host_model

// File: tb/udc_crc_check_asserts.sv
module udc_crc_check_asserts (
    input wire        ref_clk,
    input wire        resetn,
    input wire        strobe,
    input wire        term_ack,
    input wire        dmack_n,
    input wire [15:0] dd_in,
    input wire        words_done,
    input wire        cmd_end,
    input wire        burst_stop,
    input wire [15:0] word_data,
    input wire        word_valid,
    input wire [7:0]  err_reg,
    input wire        chk_flag,
    input wire [3:0]  sense_key,
    input wire        report_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    report_pulse_a: assert property (report_valid |=> !report_valid) else $error("report not a pulse");
    report_cause_a: assert property (report_valid |-> $past(cmd_end)) else $error("report without end");
    word_edge_a: assert property (word_valid |-> $past(strobe) != $past(strobe, 2)) else $error("word no edge");
    word_data_a: assert property (word_valid |-> word_data == $past(dd_in)) else $error("word data wrong");
    ack_ignore_a: assert property (term_ack && $past(term_ack) && $changed(strobe) |=> !word_valid)
        else $error("word after ack");
    dma_code_a: assert property (report_valid && err_reg != 8'h00 |-> err_reg == 8'h84 && !chk_flag)
        else $error("dma error code");
    sense_code_a: assert property (report_valid && chk_flag |-> sense_key inside {4'h4, 4'hb})
        else $error("sense key");
    stop_req_a: assert property (words_done && !dmack_n |-> ##[0:4] burst_stop) else $error("no stop");
endmodule // udc_crc_check_asserts
bind udc_crc_check udc_crc_check_asserts i_udc_crc_check_asserts (.ref_clk, .resetn, .strobe, .term_ack,
    .dmack_n, .dd_in, .words_done, .cmd_end, .burst_stop, .word_data, .word_valid, .err_reg, .chk_flag,
    .sense_key, .report_valid);

// File: tb/udc_crc_check_test.sv
module udc_crc_check_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, cmd_start = 0, cmd_end = 0;
    logic        words_done = 0, stop_seen = 0;
    logic [1:0]  reg_addr = 0, cmd_kind = 3;
    logic [15:0] reg_wdata = 0, first;
    wire         strobe, term_ack, dmack_n, burst_start, burst_stop, word_valid, chk_flag, report_valid;
    wire  [15:0] dd_in, reg_rdata, word_data;
    wire  [7:0]  err_reg, sense_asc, sense_ascq;
    wire  [3:0]  sense_key;
    int          num_errors = 0, n_compared = 0, nw = 0;
    initial forever #20 ref_clk = ~ref_clk;
    udc_crc_check i_udc_crc_check (.ref_clk, .resetn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cmd_start, .cmd_end, .cmd_kind, .burst_start, .strobe, .term_ack, .dmack_n, .dd_in,
        .words_done, .burst_stop, .word_data, .word_valid, .err_reg, .chk_flag, .sense_key, .sense_asc,
        .sense_ascq, .report_valid);
    udc_host_model i_udc_host_model (.ref_clk, .strobe, .dmack_n, .term_ack, .burst_start, .dd_in);
    always @(posedge ref_clk) begin
        if (word_valid === 1'b1) nw <= nw + 1;
        if (burst_stop === 1'b1) stop_seen <= 1'b1;
    end
    // ****************************************
    // bus tasks and checks
    // ****************************************
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [1:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [1:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
        @(negedge ref_clk);
        cmp(reg_rdata, e);
        @(posedge ref_clk);
    endtask
    task cmd(input logic [1:0] k);
        cmd_kind <= k;
        cmd_start <= 1;
        nw = 0;
        @(posedge ref_clk);
        cmd_start <= 0;
        @(posedge ref_clk);
    endtask
    // ends the command and checks the one-cycle report
    task fin(input logic ck);
        cmd_end <= 1;
        @(posedge ref_clk);
        cmd_end <= 0;
        @(negedge ref_clk);
        cmp(report_valid, 1);
        cmp(chk_flag, ck);
        @(posedge ref_clk);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_dma;
        rd(3, 16'h4aba);
        wr(0, 16'h0001);
        cmd(0);
        i_udc_host_model.burst(3, 16'h1234, 16'h0001);
        first = i_udc_host_model.crc ^ 16'h0001;
        cmp(nw, 3);
        i_udc_host_model.burst(3, 16'h5678, 16'h0100);
        i_udc_host_model.burst(1, 16'h9abc, 16'h0000);
        fin(0);
        cmp(err_reg, 16'h0084);
        rd(2, first);
        cmd(0);
        i_udc_host_model.burst(3, 16'h1234, 16'h0000);
        fin(0);
        cmp(err_reg, 0);
    endtask
    task t_pkt;
        for (int k = 2; k > 0; k--) begin
            cmd(2'(k));
            i_udc_host_model.burst(1, 16'h00ff, 16'h8000);
            fin(1);
            cmp(sense_key, (k == 1) ? 4'hb : 4'h4);
            cmp({sense_asc, sense_ascq}, 16'h0803);
        end
    endtask
    task t_mode;
        wr(0, 16'h0000);
        cmd(0);
        i_udc_host_model.burst(1, 16'h4321, 16'h0001);
        fin(0);
        cmp(err_reg, 0);
        wr(0, 16'h0003);
        cmd(0);
        words_done <= 1;
        i_udc_host_model.burst(3, 16'haaaa, 16'h0000);
        words_done <= 0;
        cmp(nw, 0);
        cmp(stop_seen, 1);
        fin(0);
        cmp(err_reg, 0);
    endtask
    task stop_test;
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1;
        t_dma;
        t_pkt;
        t_mode;
        stop_test;
    end
    initial begin
        #100us;
        num_errors++;
        stop_test;
    end
endmodule // udc_crc_check_test
